// File: shared/cfh_map.vh
// Constants for the memory-mode host port: timing figures, cycle counts and encodings
`ifndef CFH_MAP_VH
`define CFH_MAP_VH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CFH_CLK_NS        10

// ----------------------------------------------------------------
// Bus cycle timing in ns (least times, rounded up to cycles)
// ----------------------------------------------------------------
`define CFH_T_SETUP_NS    30
`define CFH_T_STROBE_NS   150
`define CFH_T_HOLD_NS     20
`define CFH_T_RESET_NS    10000

`define CFH_SETUP_CYC     ((`CFH_T_SETUP_NS  + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_STROBE_CYC    ((`CFH_T_STROBE_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_HOLD_CYC      ((`CFH_T_HOLD_NS   + `CFH_CLK_NS - 1) / `CFH_CLK_NS)
`define CFH_RESET_CYC     ((`CFH_T_RESET_NS  + `CFH_CLK_NS - 1) / `CFH_CLK_NS)

// ----------------------------------------------------------------
// Widths and pin levels
// ----------------------------------------------------------------
`define CFH_DATA_W        16
`define CFH_ADDR_W        11
`define CFH_CNT_W         16
`define CFH_SEL_COMMON    1'b1
`define CFH_SEL_ATTR      1'b0

`endif

// File: rtl/cfh_buf.v
// Two-entry read-data buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module cfh_buf #(
  parameter WIDTH = 16,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             mclk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Entry array
  reg [AW-1:0]    wr_ptr;           // Next slot to fill
  reg [AW-1:0]    rd_ptr;           // Oldest slot
  reg [AW:0]      count;            // Entries held

  wire push = in_valid_i & in_ready_o;   // Accepted word
  wire pop  = out_valid_o & out_ready_i; // Drained word

  // Full and empty come straight from the count, so they never lie
  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  // Pointer wrap is explicit so DEPTH need not be a power of two
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Data array has no reset; valid gating hides stale entries
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// File: rtl/cfh_host.v
// Host controller driving a flash card through its memory-mode pins
`timescale 1ns/1ps
`default_nettype none
`include "cfh_map.vh"

// Summary of operation
// - Word on data lines, bit 0 even byte
// - Read strobe; card drives bus then only
// - Host starts no access while busy
// - Host keeps select high for common
// - Host stretches cycle while wait low
// - Write strobe captures data into card
// - Two selects choose byte or word

module cfh_host #(
  parameter SETUP_CYC  = `CFH_SETUP_CYC,
  parameter STROBE_CYC = `CFH_STROBE_CYC,
  parameter HOLD_CYC   = `CFH_HOLD_CYC,
  parameter RESET_CYC  = `CFH_RESET_CYC
) (
  input  wire                   mclk_i,
  input  wire                   rst_i,
  // User command port
  input  wire                   cmd_valid_i,
  output wire                   cmd_ready_o,
  input  wire                   cmd_write_i,
  input  wire                   cmd_attr_i,
  input  wire [`CFH_ADDR_W-1:0] cmd_addr_i,
  input  wire [1:0]             cmd_be_i,
  input  wire [`CFH_DATA_W-1:0] cmd_wdata_i,
  input  wire                   card_reset_req_i,
  // User read data
  output wire                   rd_valid_o,
  input  wire                   rd_ready_i,
  output wire [`CFH_DATA_W-1:0] rd_data_o,
  // User status
  output wire                   card_ready_o,
  output wire                   card_wp_o,
  output wire                   busy_o,
  // Card pins
  output reg  [`CFH_ADDR_W-1:0] address_lines_o,
  input  wire [`CFH_DATA_W-1:0] data_bus_lines_i,
  output reg  [`CFH_DATA_W-1:0] data_bus_lines_o,
  output reg                    data_bus_lines_oe_o,
  output reg                    card_select_low_n_o,
  output reg                    card_select_high_n_o,
  output reg                    read_strobe_n_o,
  output reg                    write_strobe_n_o,
  output reg                    attr_select_o,
  output reg                    card_reset_o,
  output wire                   io_read_strobe_n_o,
  output wire                   io_write_strobe_n_o,
  input  wire                   ready_i,
  input  wire                   wait_n_i,
  input  wire                   write_protect_i,
  input  wire                   input_acknowledge_out_i
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_RST    = 3'h0;  // Reset pin driven high
  localparam [2:0] S_RWAIT  = 3'h1;  // Waiting for ready
  localparam [2:0] S_IDLE   = 3'h2;  // Ready for a command
  localparam [2:0] S_SETUP  = 3'h3;  // Address and selects settle
  localparam [2:0] S_STROBE = 3'h4;  // Strobe asserted
  localparam [2:0] S_HOLD   = 3'h5;  // Strobe released, address held

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg                   ready_m;   // First stage, read only by ready_s
  reg                   ready_s;   // Synchronised ready
  reg                   wait_m;    // First stage, read only by wait_s
  reg                   wait_s;    // Synchronised wait, high = go on
  reg                   wp_m;      // First stage of write protect
  reg                   wp_s;      // Synchronised write protect
  reg [`CFH_DATA_W-1:0] data_m;    // First stage of data lines
  reg [`CFH_DATA_W-1:0] data_s;    // Synchronised data lines

  // Card drives these without regard to our clock
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_m <= 1'b0;
      ready_s <= 1'b0;
      wait_m  <= 1'b1;
      wait_s  <= 1'b1;
      wp_m    <= 1'b0;
      wp_s    <= 1'b0;
      data_m  <= {`CFH_DATA_W{1'b0}};
      data_s  <= {`CFH_DATA_W{1'b0}};
    end else begin
      ready_m <= ready_i;
      ready_s <= ready_m;
      wait_m  <= wait_n_i;
      wait_s  <= wait_m;
      wp_m    <= write_protect_i;
      wp_s    <= wp_m;
      data_m  <= data_bus_lines_i;
      data_s  <= data_m;
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  reg [2:0]             state;        // Current state
  reg [2:0]             next_state;   // Following state
  reg [`CFH_CNT_W-1:0]  cnt;          // Phase countdown
  reg [`CFH_CNT_W-1:0]  next_cnt;     // Following count
  reg                   op_write;     // Latched direction
  reg [`CFH_DATA_W-1:0] op_wdata;     // Latched write word
  reg [`CFH_ADDR_W-1:0] op_addr;      // Latched address
  reg [1:0]             op_be;        // Latched byte lanes
  reg                   op_attr;      // Latched space choice
  reg                   push;         // One-cycle read word push
  reg [`CFH_DATA_W-1:0] push_data;    // Word captured at strobe end
  wire                  buf_ready;    // Buffer has a free slot

  // A read is only started when its word has a slot to land in;
  // the card gives no way to retract a read once it is strobed
  wire take = (state == S_IDLE) & ready_s & ~card_reset_req_i
              & (cmd_write_i | buf_ready);

  assign cmd_ready_o  = take;
  assign busy_o       = (state != S_IDLE);
  assign card_ready_o = ready_s;
  assign card_wp_o    = wp_s;

  // I/O strobes are parked inactive for memory mode
  assign io_read_strobe_n_o  = 1'b1;
  assign io_write_strobe_n_o = 1'b1;

  // Next-state logic
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      S_RST: begin
        // One pulse per pass; a request still high in S_RWAIT starts another; the pin is never left high
        if (cnt == {`CFH_CNT_W{1'b0}}) begin
          next_state = S_RWAIT;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_RWAIT: begin
        // Card keeps ready low until its reset work is done
        if (card_reset_req_i) begin
          next_state = S_RST;
          next_cnt   = RESET_CYC[`CFH_CNT_W-1:0] - 1'b1;
        end else if (ready_s) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (card_reset_req_i) begin
          next_state = S_RST;
          next_cnt   = RESET_CYC[`CFH_CNT_W-1:0] - 1'b1;
        end else if (cmd_valid_i & take) begin
          next_state = S_SETUP;
          next_cnt   = SETUP_CYC[`CFH_CNT_W-1:0] - 1'b1;
        end
      end
      S_SETUP: begin
        if (cnt == {`CFH_CNT_W{1'b0}}) begin
          next_state = S_STROBE;
          next_cnt   = STROBE_CYC[`CFH_CNT_W-1:0] - 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_STROBE: begin
        // Minimum width first, then stretch while wait is low
        if (cnt != {`CFH_CNT_W{1'b0}}) begin
          next_cnt = cnt - 1'b1;
        end else if (wait_s) begin
          next_state = S_HOLD;
          next_cnt   = HOLD_CYC[`CFH_CNT_W-1:0] - 1'b1;
        end
      end
      S_HOLD: begin
        if (cnt == {`CFH_CNT_W{1'b0}}) begin
          next_state = S_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = S_RST;
        next_cnt   = RESET_CYC[`CFH_CNT_W-1:0] - 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and pin registers
  // ----------------------------------------------------------------
  // Every pin but the tied-off I/O strobes comes from a flop decoded from next_state, so no glitch
  // reaches the strobes; the card is reset once at our own reset
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state                <= S_RST;
      cnt                  <= RESET_CYC[`CFH_CNT_W-1:0] - 1'b1;
      op_write             <= 1'b0;
      op_wdata             <= {`CFH_DATA_W{1'b0}};
      op_addr              <= {`CFH_ADDR_W{1'b0}};
      op_be                <= 2'h0;
      op_attr              <= 1'b0;
      push                 <= 1'b0;
      push_data            <= {`CFH_DATA_W{1'b0}};
      address_lines_o      <= {`CFH_ADDR_W{1'b0}};
      data_bus_lines_o     <= {`CFH_DATA_W{1'b0}};
      data_bus_lines_oe_o  <= 1'b0;
      card_select_low_n_o  <= 1'b1;
      card_select_high_n_o <= 1'b1;
      read_strobe_n_o      <= 1'b1;
      write_strobe_n_o     <= 1'b1;
      attr_select_o        <= `CFH_SEL_COMMON;
      card_reset_o         <= 1'b1;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      push  <= 1'b0;
      // Latch the command as it is taken
      if (cmd_valid_i & take) begin
        op_write <= cmd_write_i;
        op_wdata <= cmd_wdata_i;
        op_addr  <= cmd_addr_i;
        op_be    <= cmd_be_i;
        op_attr  <= cmd_attr_i;
      end
      // Capture the read word as the strobe ends
      if ((state == S_STROBE) & (next_state == S_HOLD) & ~op_write) begin
        push      <= 1'b1;
        push_data <= data_s;
      end
      card_reset_o <= (next_state == S_RST);
      if ((next_state == S_SETUP) | (next_state == S_STROBE) | (next_state == S_HOLD)) begin
        // Address, space and lanes stand across the whole cycle
        address_lines_o      <= (state == S_IDLE) ? cmd_addr_i : op_addr;
        attr_select_o        <= ((state == S_IDLE) ? cmd_attr_i : op_attr)
                                ? `CFH_SEL_ATTR : `CFH_SEL_COMMON;
        card_select_low_n_o  <= ~((state == S_IDLE) ? cmd_be_i[0] : op_be[0]);
        card_select_high_n_o <= ~((state == S_IDLE) ? cmd_be_i[1] : op_be[1]);
        // Host drives the bus only for writes, never under a read strobe
        data_bus_lines_oe_o  <= (state == S_IDLE) ? cmd_write_i : op_write;
        data_bus_lines_o     <= (state == S_IDLE) ? cmd_wdata_i : op_wdata;
      end else begin
        card_select_low_n_o  <= 1'b1;
        card_select_high_n_o <= 1'b1;
        data_bus_lines_oe_o  <= 1'b0;
        attr_select_o        <= `CFH_SEL_COMMON;
      end
      read_strobe_n_o  <= ~((next_state == S_STROBE) & ~op_write);
      write_strobe_n_o <= ~((next_state == S_STROBE) & op_write);
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  // Two entries let the user stall for a word without losing one
  cfh_buf #(
    .WIDTH (`CFH_DATA_W),
    .DEPTH (2),
    .AW    (1)
  ) u_buf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (push_data),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );

endmodule

`default_nettype wire

// File: verif/cfh_host_monitor.sv
// Checker of the pin-level behaviour of the memory-mode host port
`timescale 1ns/1ps
`default_nettype none

module cfh_host_monitor #(
  parameter RESET_CYC = 8
) (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        cmd_ready_o,
  input wire logic        card_ready_o,
  input wire logic [10:0] address_lines_o,
  input wire logic        data_bus_lines_oe_o,
  input wire logic        card_select_low_n_o,
  input wire logic        card_select_high_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        attr_select_o,
  input wire logic        card_reset_o,
  input wire logic        io_read_strobe_n_o,
  input wire logic        io_write_strobe_n_o,
  input wire logic        wait_n_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  wire         strobe_low = !read_strobe_n_o || !write_strobe_n_o; // Any strobe active
  wire         sel_on     = !(card_select_low_n_o && card_select_high_n_o); // Card selected
  logic [15:0] rst_cnt;                                          // Cycles reset pin high

  // Count reset pin cycles apart from the design's own down-counter
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cnt <= 16'h0000;
    end else if (card_reset_o) begin
      rst_cnt <= rst_cnt + 16'h0001;
    end else begin
      rst_cnt <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Strobe length assumes the default of 15 strobe cycles
  sequence s_low8; strobe_low [*8]; endsequence
  sequence s_low7; strobe_low [*7]; endsequence
  sequence s_hold; sel_on [*2]; endsequence

  property p_io_idle; io_read_strobe_n_o && io_write_strobe_n_o; endproperty
  property p_rd_oe; !read_strobe_n_o |-> !data_bus_lines_oe_o && write_strobe_n_o; endproperty
  property p_wr_oe; !write_strobe_n_o |-> data_bus_lines_oe_o; endproperty
  property p_sel; strobe_low |-> sel_on; endproperty
  property p_hold; $fell(strobe_low) |-> s_hold; endproperty
  property p_min; $rose(strobe_low) |-> s_low8 ##1 s_low7; endproperty
  property p_addr; strobe_low && $past(strobe_low) |->
    $stable(address_lines_o) && $stable(attr_select_o); endproperty
  property p_wait; strobe_low && !wait_n_i && !$past(wait_n_i) && !$past(wait_n_i, 2)
    |=> strobe_low; endproperty
  property p_refuse; !card_ready_o || card_reset_o |-> !cmd_ready_o && !strobe_low; endproperty
  property p_rst_len; $fell(card_reset_o) |-> rst_cnt == RESET_CYC; endproperty

  a_io_idle: assert property (p_io_idle) else $error("io strobe driven");
  a_rd_oe: assert property (p_rd_oe) else $error("bus driven in read");
  a_wr_oe: assert property (p_wr_oe) else $error("bus idle in write");
  a_sel: assert property (p_sel) else $error("strobe without select");
  a_hold: assert property (p_hold) else $error("select hold short");
  a_min: assert property (p_min) else $error("strobe too short");
  a_addr: assert property (p_addr) else $error("address moved in strobe");
  a_wait: assert property (p_wait) else $error("wait not honoured");
  a_refuse: assert property (p_refuse) else $error("access while busy");
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
endmodule

bind cfh_host cfh_host_monitor #(.RESET_CYC(RESET_CYC)) cfh_host_monitor_i (
  .mclk_i, .rst_i, .cmd_ready_o, .card_ready_o, .address_lines_o, .data_bus_lines_oe_o,
  .card_select_low_n_o, .card_select_high_n_o, .read_strobe_n_o, .write_strobe_n_o,
  .attr_select_o, .card_reset_o, .io_read_strobe_n_o, .io_write_strobe_n_o, .wait_n_i
);
`default_nettype wire

// File: verif/cfh_card_model.sv
// Behavioural model of the card behind the memory-mode pins
`timescale 1ns/1ps
`default_nettype none

module cfh_card_model #(
  parameter BUSY_CYC = 20
) (
  input  wire logic        mclk_i,
  input  wire logic        card_reset_i,
  input  wire logic [10:0] address_lines_i,
  input  wire logic [15:0] bus_i,
  input  wire logic        card_select_low_n_i,
  input  wire logic        card_select_high_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        attr_select_i,
  input  wire logic [7:0]  wait_len_i,
  output wire logic [15:0] data_o,
  output wire logic        ready_o,
  output wire logic        wait_n_o,
  output wire logic        write_protect_o,
  output wire logic        battery_detect_one_o,
  output wire logic        battery_detect_two_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] mem [0:63]; // Common words low half, attribute words high half
  logic [15:0] last_q;     // Last bus value, inverted when released
  int          busy_cnt;   // Reset processing cycles left
  int          age;        // Cycles since a strobe fell
  logic        pin_armed;  // Reset pin seen low since power-up
  wire         rst_eff = card_reset_i && pin_armed; // Reset pin acting
  wire  [5:0]  idx = {~attr_select_i, address_lines_i[4:0]};

  // I/O strobes and acknowledge are not wired in: ignored in this mode
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    last_q = 16'h0000;
    busy_cnt = BUSY_CYC;
    age = 0;
    pin_armed = 1'b0;
  end

  // Battery detection is not supported, so both lines stand high
  assign battery_detect_one_o = 1'b1;
  assign battery_detect_two_o = 1'b1;

  // Busy while the reset pin is high and for a while after it falls
  // A pin held high from power-up gives only the power-up reset, never a stuck busy
  always @(posedge mclk_i) begin
    if (!card_reset_i) pin_armed <= 1'b1;
    if (rst_eff) begin
      busy_cnt <= BUSY_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  assign ready_o = (busy_cnt == 0) && !rst_eff;
  assign write_protect_o = !ready_o;

  // Wait pulse starts two cycles into a strobe, early enough for the host sync
  always @(posedge mclk_i) begin
    age <= (read_strobe_n_i && write_strobe_n_i) ? 0 : age + 1;
  end
  assign wait_n_o = !(age >= 2 && age < 2 + wait_len_i);

  // Drive only during a selected read; a released bus toggles so stale data never matches
  assign data_o = (!read_strobe_n_i && !(card_select_low_n_i && card_select_high_n_i))
                  ? mem[idx] : ~last_q;
  always @(posedge mclk_i) last_q <= data_o;

  // Capture on the rising write strobe, one lane per select
  always @(posedge write_strobe_n_i) begin
    if (!card_select_low_n_i) mem[idx][7:0] <= bus_i[7:0];
    if (!card_select_high_n_i) mem[idx][15:8] <= bus_i[15:8];
  end
endmodule
`default_nettype wire

// File: verif/test_flash_card_memory_mode_port.sv
// Self-checking testbench of the memory-mode host port
`timescale 1ns/1ps
`default_nettype none

module test_flash_card_memory_mode_port;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
  logic        cmd_attr_i = 1'b0, card_reset_req_i = 1'b0, rd_ready_i = 1'b0;
  logic        input_acknowledge_out_i = 1'b0;     // Unused by the host in this mode
  logic [10:0] cmd_addr_i = 11'h000;
  logic [10:0] tgt_addr = 11'h005;                  // Card address of every command
  logic [1:0]  cmd_be_i = 2'b11;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic [7:0]  wait_len = 8'h00;                    // Wait cycles asked of the card
  wire         cmd_ready_o, rd_valid_o, card_ready_o, card_wp_o, busy_o, data_bus_lines_oe_o;
  wire         card_select_low_n_o, card_select_high_n_o, read_strobe_n_o, write_strobe_n_o;
  wire         attr_select_o, card_reset_o, io_read_strobe_n_o, io_write_strobe_n_o;
  wire         ready_i, wait_n_i, write_protect_i;
  wire  [10:0] address_lines_o;
  wire  [15:0] rd_data_o, data_bus_lines_o, data_bus_lines_i;
  wire  [15:0] host_bus = data_bus_lines_oe_o ? data_bus_lines_o : ~data_bus_lines_o;
  int          n_fail = 0, cmp_count = 0, cyc = 0, rs_run = 0, rs_len = 0;

  cfh_host #(.RESET_CYC(8)) cfh_host_i (.*);
  cfh_card_model cfh_card_model_i (.mclk_i, .card_reset_i(card_reset_o),
    .address_lines_i(address_lines_o), .bus_i(host_bus),
    .card_select_low_n_i(card_select_low_n_o), .card_select_high_n_i(card_select_high_n_o),
    .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .attr_select_i(attr_select_o), .wait_len_i(wait_len), .data_o(data_bus_lines_i),
    .ready_o(ready_i), .wait_n_o(wait_n_i), .write_protect_o(write_protect_i),
    .battery_detect_one_o(), .battery_detect_two_o());

  always #5 mclk_i = ~mclk_i;

  // Read strobe length and the hang limit; a run takes a few hundred cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    rs_run <= read_strobe_n_o ? 0 : rs_run + 1;
    if (!read_strobe_n_o) rs_len <= rs_run + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Held at the falling edge until ready shows, so it is taken at the next rise
  task automatic cmd(input logic wr, input logic at, input logic [1:0] be, input logic [15:0] d);
    @(negedge mclk_i);
    {cmd_valid_i, cmd_write_i, cmd_attr_i, cmd_addr_i, cmd_be_i, cmd_wdata_i} =
      {1'b1, wr, at, tgt_addr, be, d};
    for (int n = 0; n < 3000 && cmd_ready_o !== 1'b1; n++) @(negedge mclk_i);
    chk("cmd taken", cmd_ready_o, 1'b1);
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
  endtask

  // One edge passes first, so back-to-back pops never reassign ready in one step
  task automatic pop(input string what, input logic [15:0] exp);
    @(negedge mclk_i);
    for (int n = 0; n < 3000 && rd_valid_o !== 1'b1; n++) @(negedge mclk_i);
    chk("read valid", rd_valid_o, 1'b1);
    chk(what, rd_data_o, exp);
    rd_ready_i = 1'b1;
    @(negedge mclk_i);
    rd_ready_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_start;
    @(negedge mclk_i);
    chk("reset pin", card_reset_o, 1'b1);
    chk("busy refused", cmd_ready_o, 1'b0);
    chk("card busy", card_ready_o, 1'b0);
    for (int n = 0; n < 3000 && cmd_ready_o !== 1'b1; n++) @(negedge mclk_i);
    chk("write protect", card_wp_o, 1'b0);
    chk("io strobes", {io_read_strobe_n_o, io_write_strobe_n_o}, 2'b11);
    chk("select idle", attr_select_o, 1'b1);
    $display("t_start done");
  endtask

  task automatic t_lanes;
    cmd(1'b1, 1'b0, 2'b11, 16'h12A5);
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("word", 16'h12A5);
    chk("strobe length", rs_len, 16'h000F);
    cmd(1'b1, 1'b0, 2'b01, 16'hFF3C);
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("even byte", 16'h123C);
    cmd(1'b1, 1'b0, 2'b10, 16'h77FF);
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("odd byte", 16'h773C);
    $display("t_lanes done");
  endtask

  // Two reads fill the buffer while the user stalls; a third read is refused
  task automatic t_attr_buf;
    cmd(1'b1, 1'b1, 2'b11, 16'h0BEE);
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    cmd(1'b0, 1'b1, 2'b11, 16'h0000);
    for (int n = 0; n < 3000 && busy_o !== 1'b0; n++) @(negedge mclk_i);
    {cmd_valid_i, cmd_write_i} = 2'b10;
    repeat (10) @(negedge mclk_i);
    chk("full refused", cmd_ready_o, 1'b0);
    cmd_valid_i = 1'b0;
    pop("common space", 16'h773C);
    pop("attribute space", 16'h0BEE);
    chk("drained", rd_valid_o, 1'b0);
    $display("t_attr_buf done");
  endtask

  task automatic t_wait;
    wait_len = 8'd20;
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("waited read", 16'h773C);
    chk("stretched", rs_len > 15, 1'b1);
    wait_len = 8'h00;
    $display("t_wait done");
  endtask

  task automatic t_card_reset;
    @(negedge mclk_i);
    card_reset_req_i = 1'b1;
    for (int n = 0; n < 100 && card_reset_o !== 1'b1; n++) @(negedge mclk_i);
    card_reset_req_i = 1'b0;
    chk("reset pulse", card_reset_o, 1'b1);
    chk("reset refused", cmd_ready_o, 1'b0);
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("after reset", 16'h773C);
    tgt_addr = 11'h006;
    cmd(1'b0, 1'b0, 2'b11, 16'h0000);
    pop("other address", 16'h0000);
    $display("t_card_reset done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    t_start();
    t_lanes();
    t_attr_buf();
    t_wait();
    t_card_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
